// ### inc/amss_pkg.sv
package amss_pkg;
  localparam int ADDR_W = 24;
  localparam int DATA_W = 32;
  localparam int BANK_W = 2;
  localparam int NBANK = 4;
  localparam int CNT_W = 4;
  localparam int FIFO_DEPTH = 4;
  localparam int CMD_W = 1 + BANK_W + ADDR_W + DATA_W;
  // Memory bus clock period in pclk cycles
  localparam int MCLK_DIV = 2;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CMD = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_RDATA = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam int CTRL_EN = 0;
  localparam int CTRL_PRECHARGE_DISABLE = 1;
  localparam int CTRL_WAIT_LSB = 4;
  localparam int CTRL_RHC_LSB = 8;
  localparam int CTRL_HOLD_LSB = 12;
  localparam int CTRL_IDLE_LSB = 16;
  localparam logic [31:0] CTRL_RESET = 32'h0001_0121;
  localparam int CMD_WRITE_BIT = 31;
  localparam int CMD_BANK_LSB = 24;
  localparam int ST_BUSY = 0;
  localparam int ST_RVALID = 1;
  localparam int ST_FULL = 2;
  localparam int ST_EMPTY = 3;
  // Extra strobe-high gaps, in memory bus clock periods
  localparam logic [CNT_W-1:0] GAP_PRECHARGE_DISABLE = 4'h3;
  localparam logic [CNT_W-1:0] GAP_RD_WR = 4'h4;
  localparam logic [CNT_W-1:0] GAP_WR_RD = 4'h2;
  typedef enum logic [1:0] {
    AMSS_IDLE = 2'b00,
    AMSS_SETUP = 2'b01,
    AMSS_STROBE = 2'b10,
    AMSS_HOLD = 2'b11
  } amss_state_e;
endpackage

// ### rtl/amss_sequencer.sv
// Implementation choices: the register addresses and the APB register port.

module amss_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wp;
  logic [PW-1:0] rp;
  logic [PW:0] level;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  assign in_ready = (level != (PW+1)'(DEPTH));
  assign out_valid = (level != '0);
  assign out_data = mem[rp];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp <= '0;
      rp <= '0;
      level <= '0;
    end else begin
      if (push) begin
        wp <= (wp == PW'(DEPTH-1)) ? '0 : wp + 1'b1;
      end
      if (pop) begin
        rp <= (rp == PW'(DEPTH-1)) ? '0 : rp + 1'b1;
      end
      level <= level + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule

module amss_sequencer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic memory_bus_clock,
  output logic [amss_pkg::NBANK-1:0] bank_select_n,
  output logic [amss_pkg::ADDR_W-1:0] mem_addr,
  output logic async_read_strobe_n,
  output logic async_write_strobe_n,
  output logic [amss_pkg::DATA_W-1:0] mem_data_out,
  output logic mem_data_oe,
  input wire logic [amss_pkg::DATA_W-1:0] mem_data_in,
  input wire logic access_extend_ack
);
  localparam int CW = amss_pkg::CNT_W;

  // Registers
  logic [31:0] ctrl;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic rvalid;

  // Pin synchronisers
  logic ack_s1;
  logic ack_s2;
  logic [amss_pkg::DATA_W-1:0] din_s1;
  logic [amss_pkg::DATA_W-1:0] din_s2;

  // Memory bus clock divider
  logic [$clog2(amss_pkg::MCLK_DIV)-1:0] div_cnt;
  logic tick;

  // Sequencer
  amss_pkg::amss_state_e state;
  amss_pkg::amss_state_e next_state;
  logic [CW-1:0] cnt;
  logic [CW-1:0] gap_cnt;
  logic cur_write;
  logic [amss_pkg::BANK_W-1:0] cur_bank;
  logic last_valid;
  logic last_write;
  logic [amss_pkg::BANK_W-1:0] last_bank;

  // Control fields
  wire en = ctrl[amss_pkg::CTRL_EN];
  wire precharge_disable = ctrl[amss_pkg::CTRL_PRECHARGE_DISABLE];
  wire [CW-1:0] wait_raw = ctrl[amss_pkg::CTRL_WAIT_LSB +: CW];
  wire [CW-1:0] wait_states = (wait_raw == '0) ? CW'(1) : wait_raw;
  wire [CW-1:0] read_hold_count = ctrl[amss_pkg::CTRL_RHC_LSB +: CW];
  wire [CW-1:0] hold_count = ctrl[amss_pkg::CTRL_HOLD_LSB +: CW];
  wire [CW-1:0] idle_count = ctrl[amss_pkg::CTRL_IDLE_LSB +: CW];

  // APB decode
  wire acc = psel && penable;
  wire sel_ctrl = (paddr == amss_pkg::REG_CTRL);
  wire sel_cmd = (paddr == amss_pkg::REG_CMD);
  wire sel_wdata = (paddr == amss_pkg::REG_WDATA);
  wire sel_rdata = (paddr == amss_pkg::REG_RDATA);
  wire sel_status = (paddr == amss_pkg::REG_STATUS);
  wire mapped = sel_ctrl | sel_cmd | sel_wdata | sel_rdata | sel_status;

  // Command FIFO
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [amss_pkg::CMD_W-1:0] fifo_out;
  wire cmd_push_req = acc && pwrite && sel_cmd;
  wire [amss_pkg::CMD_W-1:0] fifo_in = {pwdata[amss_pkg::CMD_WRITE_BIT],
    pwdata[amss_pkg::CMD_BANK_LSB +: amss_pkg::BANK_W],
    pwdata[amss_pkg::ADDR_W-1:0], wdata};

  // A full FIFO stalls the APB access rather than dropping the command
  assign pready = !cmd_push_req || fifo_in_ready;
  assign pslverr = acc && !mapped;

  wire wr_en = acc && pready && pwrite && mapped;
  wire rd_rdata = acc && pready && !pwrite && sel_rdata;

  wire busy = (state != amss_pkg::AMSS_IDLE);
  wire [31:0] status = {28'h0000000, !fifo_out_valid, !fifo_in_ready, rvalid, busy};
  assign prdata = !(psel && !pwrite) ? 32'h0000_0000 :
                  sel_ctrl ? ctrl :
                  sel_wdata ? wdata :
                  sel_rdata ? rdata :
                  sel_status ? status : 32'h0000_0000;

  amss_fifo #(
    .WIDTH(amss_pkg::CMD_W),
    .DEPTH(amss_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk(pclk),
    .rst_n(presetn),
    .in_valid(cmd_push_req),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out)
  );

  wire nxt_write = fifo_out[amss_pkg::CMD_W-1];
  wire [amss_pkg::BANK_W-1:0] nxt_bank =
    fifo_out[amss_pkg::ADDR_W + amss_pkg::DATA_W +: amss_pkg::BANK_W];
  wire [amss_pkg::ADDR_W-1:0] nxt_addr =
    fifo_out[amss_pkg::DATA_W +: amss_pkg::ADDR_W];
  wire [amss_pkg::DATA_W-1:0] nxt_data = fifo_out[amss_pkg::DATA_W-1:0];

  // Extra strobe-high periods needed beyond the hold, by access pair
  wire same_bank = (nxt_bank == last_bank);
  wire [CW-1:0] idle_or_3 = (idle_count > amss_pkg::GAP_PRECHARGE_DISABLE) ? idle_count : amss_pkg::GAP_PRECHARGE_DISABLE;
  wire [CW-1:0] idle_or_4 = (idle_count > amss_pkg::GAP_RD_WR) ? idle_count : amss_pkg::GAP_RD_WR;
  wire [CW-1:0] gap_rr = same_bank ? (precharge_disable ? amss_pkg::GAP_PRECHARGE_DISABLE : '0) :
                         (precharge_disable ? idle_or_3 : idle_count);
  wire [CW-1:0] gap_need = !last_valid ? '0 :
                           (last_write ? (nxt_write ? '0 : amss_pkg::GAP_WR_RD) :
                           (nxt_write ? idle_or_4 : gap_rr));
  // Nothing starts unless the port is in asynchronous access mode
  wire start = tick && en && fifo_out_valid && (gap_cnt >= gap_need);

  assign fifo_out_ready = (state == amss_pkg::AMSS_IDLE) && start;

  wire strobe_done = (cnt == CW'(1)) && ack_s2;
  wire hold_done = (cnt == '0);

  always_comb begin
    next_state = state;
    case (state)
      amss_pkg::AMSS_IDLE: begin
        if (start) begin
          next_state = amss_pkg::AMSS_SETUP;
        end
      end
      amss_pkg::AMSS_SETUP: begin
        next_state = amss_pkg::AMSS_STROBE;
      end
      amss_pkg::AMSS_STROBE: begin
        if (strobe_done) begin
          next_state = amss_pkg::AMSS_HOLD;
        end
      end
      amss_pkg::AMSS_HOLD: begin
        if (hold_done) begin
          next_state = amss_pkg::AMSS_IDLE;
        end
      end
      default: begin
        next_state = amss_pkg::AMSS_IDLE;
      end
    endcase
  end

  // Divider for the memory bus clock enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt <= '0;
      tick <= 1'b0;
      memory_bus_clock <= 1'b0;
    end else begin
      tick <= (div_cnt == '0);
      div_cnt <= (div_cnt == ($bits(div_cnt))'(amss_pkg::MCLK_DIV - 1)) ? '0 : div_cnt + 1'b1;
      memory_bus_clock <= (div_cnt < ($bits(div_cnt))'(amss_pkg::MCLK_DIV / 2));
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_s1 <= 1'b1;
      ack_s2 <= 1'b1;
      din_s1 <= '0;
      din_s2 <= '0;
    end else begin
      ack_s1 <= access_extend_ack;
      ack_s2 <= ack_s1;
      din_s1 <= mem_data_in;
      din_s2 <= din_s1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= amss_pkg::CTRL_RESET;
      wdata <= '0;
    end else if (wr_en) begin
      if (sel_ctrl) begin
        ctrl <= pwdata;
      end
      if (sel_wdata) begin
        wdata <= pwdata;
      end
    end
  end

  // Sequencer state and counters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= amss_pkg::AMSS_IDLE;
      cnt <= '0;
      gap_cnt <= '0;
      cur_write <= 1'b0;
      cur_bank <= '0;
      last_valid <= 1'b0;
      last_write <= 1'b0;
      last_bank <= '0;
    end else if (tick) begin
      state <= next_state;
      case (state)
        amss_pkg::AMSS_IDLE: begin
          if (gap_cnt != '1) begin
            gap_cnt <= gap_cnt + 1'b1;
          end
          if (start) begin
            cur_write <= nxt_write;
            cur_bank <= nxt_bank;
          end
        end
        amss_pkg::AMSS_SETUP: begin
          cnt <= wait_states;
        end
        amss_pkg::AMSS_STROBE: begin
          if (strobe_done) begin
            cnt <= cur_write ? hold_count : read_hold_count;
          end else if (cnt != CW'(1)) begin
            cnt <= cnt - 1'b1;
          end
        end
        amss_pkg::AMSS_HOLD: begin
          if (hold_done) begin
            gap_cnt <= '0;
            last_valid <= 1'b1;
            last_write <= cur_write;
            last_bank <= cur_bank;
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        default: begin
          cnt <= '0;
        end
      endcase
    end
  end

  // Pin outputs, all registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bank_select_n <= '1;
      mem_addr <= '0;
      async_read_strobe_n <= 1'b1;
      async_write_strobe_n <= 1'b1;
      mem_data_out <= '0;
      mem_data_oe <= 1'b0;
    end else if (tick) begin
      case (state)
        amss_pkg::AMSS_IDLE: begin
          if (start) begin
            bank_select_n <= ~(amss_pkg::NBANK'(1) << nxt_bank);
            mem_addr <= nxt_addr;
            mem_data_out <= nxt_data;
          end
        end
        amss_pkg::AMSS_SETUP: begin
          async_read_strobe_n <= cur_write;
          async_write_strobe_n <= !cur_write;
          mem_data_oe <= cur_write;
        end
        amss_pkg::AMSS_STROBE: begin
          if (strobe_done) begin
            async_read_strobe_n <= 1'b1;
            async_write_strobe_n <= 1'b1;
            if (cur_write ? (hold_count == '0) : (read_hold_count == '0)) begin
              bank_select_n <= '1;
              mem_data_oe <= 1'b0;
            end
          end
        end
        amss_pkg::AMSS_HOLD: begin
          if (cnt == CW'(1) || hold_done) begin
            bank_select_n <= '1;
            mem_data_oe <= 1'b0;
          end
        end
        default: begin
          bank_select_n <= '1;
        end
      endcase
    end
  end

  // Read data taken as the read strobe rises; new data wins over a clearing read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata <= '0;
      rvalid <= 1'b0;
    end else if (tick && state == amss_pkg::AMSS_STROBE && strobe_done && !cur_write) begin
      rdata <= din_s2;
      rvalid <= 1'b1;
    end else if (rd_rdata) begin
      rvalid <= 1'b0;
    end
  end
endmodule

// ### test/amss_mem_model.sv
module amss_mem_model (
  input wire logic clk,
  input wire logic [amss_pkg::ADDR_W-1:0] mem_addr,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [amss_pkg::DATA_W-1:0] wdata,
  input wire logic [7:0] stall,
  output logic [amss_pkg::DATA_W-1:0] rdata,
  output logic ack
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [amss_pkg::DATA_W-1:0] mem [16];
  logic [7:0] n = 8'h0;
  logic [1:0] tail = 2'h0;
  logic busy = 1'b0;
  initial rdata = '0;
  assign ack = n == 8'h0;
  always @(posedge clk) begin
    busy <= !(rd_n && wr_n);
    if (!wr_n) mem[mem_addr[3:0]] <= wdata;
    if (!(rd_n && wr_n) && !busy) n <= stall;
    else if (n != 8'h0) n <= n - 8'h1;
    tail <= rd_n ? tail - {1'b0, tail != 2'h0} : 2'h2;
    // Released bus toggles so a stale word cannot pass for a capture
    rdata <= (!rd_n || tail != 2'h0) ? mem[mem_addr[3:0]] : ~rdata;
  end
endmodule

// ### test/amss_properties.sv
module amss_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [amss_pkg::NBANK-1:0] bank_select_n,
  input wire logic [amss_pkg::ADDR_W-1:0] mem_addr,
  input wire logic async_read_strobe_n,
  input wire logic async_write_strobe_n,
  input wire logic [amss_pkg::DATA_W-1:0] mem_data_out,
  input wire logic mem_data_oe,
  input wire logic access_extend_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] ctrl;
  logic [7:0] lo, hi, oe_off;
  logic ext, was_wr;
  wire idle = bank_select_n == 4'hf;
  wire strobe = !(async_read_strobe_n && async_write_strobe_n);
  wire [3:0] w_st = (ctrl[7:4] == 4'h0) ? 4'h1 : ctrl[7:4];
  // Any ack dip marks the access as extended, so width checks skip it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= amss_pkg::CTRL_RESET;
      lo <= 8'h0;
      hi <= 8'h0;
      oe_off <= 8'hff;
      ext <= 1'b0;
      was_wr <= 1'b0;
    end else begin
      if (psel && penable && pready && pwrite && paddr == amss_pkg::REG_CTRL) ctrl <= pwdata;
      lo <= strobe ? lo + 8'h1 : 8'h0;
      hi <= (strobe || idle) ? 8'h0 : hi + 8'h1;
      oe_off <= mem_data_oe ? 8'h0 : oe_off + {7'h0, oe_off != 8'hff};
      ext <= idle ? 1'b0 : (ext || !access_extend_ack);
      if (strobe) was_wr <= !async_write_strobe_n;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence start_of(s);
    $fell(s) && bank_select_n != 4'hf;
  endsequence
  rd_lead_a: assert property (start_of(async_read_strobe_n) |-> $past(bank_select_n, 2) != 4'hf)
    else $error("read strobe without select lead");
  wr_lead_a: assert property (start_of(async_write_strobe_n) |-> $past(bank_select_n, 2) != 4'hf)
    else $error("write strobe without select lead");
  rd_width_a: assert property ($rose(async_read_strobe_n) && !ext |-> lo == {3'h0, w_st, 1'b0})
    else $error("read strobe width wrong");
  wr_width_a: assert property ($rose(async_write_strobe_n) && !ext |-> lo == {3'h0, w_st, 1'b0})
    else $error("write strobe width wrong");
  rd_hold_a: assert property ($rose(idle) && !was_wr |-> hi == {3'h0, ctrl[11:8], 1'b0})
    else $error("read select hold wrong");
  wr_hold_a: assert property ($rose(idle) && was_wr |-> hi == {3'h0, ctrl[15:12], 1'b0})
    else $error("write select hold wrong");
  wr_data_a: assert property (!async_write_strobe_n |-> mem_data_oe && $stable(mem_data_out))
    else $error("write data not held under strobe");
  oe_early_a: assert property ($fell(async_write_strobe_n) |-> mem_data_oe)
    else $error("write data not driven at strobe");
  oe_idle_a: assert property ($fell(async_read_strobe_n) |-> oe_off >= 8'd4)
    else $error("data bus driven too close to read");
  mode_gate_a: assert property ($fell(idle) |-> ctrl[0])
    else $error("access started while disabled");
  bad_addr_a: assert property (psel && penable && paddr > 8'h10 |-> pslverr)
    else $error("unmapped access not flagged");
endmodule
bind amss_sequencer amss_props u_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
  .pslverr, .bank_select_n, .mem_addr, .async_read_strobe_n, .async_write_strobe_n, .mem_data_out,
  .mem_data_oe, .access_extend_ack);

// ### test/test_amss_sequencer.sv
module test_amss_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h0, stall = 8'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd, dout, din;
  logic pready, pslverr, rd_n, wr_n, oe, ack, err, mclk, m0;
  logic [3:0] sel;
  logic [23:0] maddr;
  int n_mismatch = 0, n_compared = 0, g = 0, lo_w = 0, w_last = 0;
  int gaps[$];
  always #5 pclk = ~pclk;
  amss_sequencer dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .memory_bus_clock(mclk), .bank_select_n(sel), .mem_addr(maddr), .async_read_strobe_n(rd_n),
    .async_write_strobe_n(wr_n), .mem_data_out(dout), .mem_data_oe(oe), .mem_data_in(din),
    .access_extend_ack(ack));
  amss_mem_model mem (.clk(pclk), .mem_addr(maddr), .rd_n, .wr_n, .wdata(dout), .stall, .rdata(din), .ack);
  always @(posedge pclk) begin
    if (rd_n && wr_n) g++;
    else if (g > 0) begin
      gaps.push_back(g);
      g = 0;
    end
    if (!rd_n) lo_w++;
    else if (lo_w > 0) begin
      w_last = lo_w;
      lo_w = 0;
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 100);
    if (k >= 100) n_mismatch++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic drain;
    int k;
    k = 0;
    do begin
      apb(1'b0, amss_pkg::REG_STATUS, 32'h0);
      k++;
    end while ((rd & 32'h9) !== 32'h8 && k < 100);
    if (k >= 100) n_mismatch++;
  endtask
  // Commands wait in a full queue, then run back to back so gaps are minimal
  task automatic burst(input logic [31:0] ctl, input logic [31:0] c[4], input int e[3]);
    apb(1'b1, amss_pkg::REG_CTRL, ctl);
    foreach (c[i]) begin
      apb(1'b1, amss_pkg::REG_WDATA, {8'h5a, c[i][23:0]});
      apb(1'b1, amss_pkg::REG_CMD, c[i]);
    end
    apb(1'b0, amss_pkg::REG_STATUS, 32'h0);
    check(rd & 32'h5, 32'h4);
    check({30'h0, rd_n, wr_n}, 32'h3);
    gaps.delete();
    apb(1'b1, amss_pkg::REG_CTRL, ctl | 32'h1);
    drain;
    foreach (e[i]) check(32'(gaps[i + 1]), 32'(e[i]));
    $display("burst with control %h done", ctl);
  endtask
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, amss_pkg::REG_CTRL, 32'h0);
    check(rd, amss_pkg::CTRL_RESET);
    apb(1'b0, amss_pkg::REG_STATUS, 32'h0);
    check(rd, 32'h8);
    apb(1'b0, amss_pkg::REG_CMD, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    check({rd[30:0], err}, 32'h1);
    // Memory bus clock is a pclk/2 square wave
    m0 = mclk;
    @(posedge pclk);
    check({31'h0, mclk}, {31'h0, ~m0});
    $display("register reset test done");
    // Wait 2, read hold 1, hold 2, idle 1; the state pipeline adds three periods to every gap
    burst(32'h0001_2120, '{32'h8000_0001, 32'h8000_0002, 32'h1, 32'h1}, '{10, 14, 8});
    apb(1'b0, amss_pkg::REG_RDATA, 32'h0);
    check(rd, 32'h5a00_0001);
    burst(32'h0001_2122, '{32'h1, 32'h1, 32'h0200_0001, 32'h8200_0002}, '{14, 14, 16});
    burst(32'h0001_2120, '{32'h1, 32'h0100_0001, 32'h8100_0003, 32'h8100_0003}, '{10, 16, 10});
    stall <= 8'd12;
    apb(1'b1, amss_pkg::REG_CMD, 32'h0100_0003);
    drain;
    check(32'(w_last >= 12), 32'h1);
    apb(1'b0, amss_pkg::REG_RDATA, 32'h0);
    check(rd, 32'h5a00_0003);
    stall <= 8'd0;
    $display("extended read test done");
    test_done;
  end
  initial begin
    repeat (6000) @(posedge pclk);
    n_mismatch++;
    test_done;
  end
endmodule
